// File: logic/dfg_filter.sv
// icmp flood guard: paged registers, per-frame discard decision, decision fifo
`timescale 1ns/100ps
`include "dfg_defines.svh"

// ****************************************************************
// decision fifo
// ****************************************************************
module dfg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  import dfg_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  logic out_load;

  assign in_ready_o = (count_reg != DEPTH[AW:0]);
  assign push = in_valid_i && in_ready_o;
  assign out_load = !out_valid_o || out_ready_i;
  assign pop = out_load && (count_reg != '0);

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_reg[wptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (pop)
      begin
        rptr_reg <= rptr_reg + 1'b1;
      end
      count_reg <= count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  // registered head so the consumer sees flop outputs
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      out_valid_o <= 1'b0;
      out_data_o <= '0;
    end
    else if (out_load)
    begin
      out_valid_o <= pop;
      if (pop)
      begin
        out_data_o <= mem_reg[rptr_reg];
      end
    end
  end
endmodule

// ****************************************************************
// filter top
// ****************************************************************
module dfg_filter #(
  parameter int TAG_W = 8,
  parameter int PORT_W = 9,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic reg_req_i,
  input wire logic reg_wr_i,
  input wire dfg_pkg::dfg_byte_t reg_addr_i,
  input wire dfg_pkg::dfg_byte_t reg_wdata_i,
  output dfg_pkg::dfg_byte_t reg_rdata_o,
  output logic reg_ack_o,
  input wire logic hdr_valid_i,
  output logic hdr_ready_o,
  input wire logic [TAG_W-1:0] hdr_tag_i,
  input wire logic hdr_ipv4_i,
  input wire logic hdr_ipv6_i,
  input wire logic hdr_icmp_i,
  input wire logic hdr_echo_req_i,
  input wire logic hdr_fragment_i,
  input wire dfg_pkg::dfg_len_t hdr_ip_len_i,
  input wire dfg_pkg::dfg_byte_t hdr_ip_hdr_len_i,
  input wire logic hdr_learn_i,
  input wire logic [PORT_W-1:0] hdr_fwd_mask_i,
  input wire logic [PORT_W-1:0] hdr_mirror_mask_i,
  output logic dec_valid_o,
  input wire logic dec_ready_i,
  output logic [TAG_W-1:0] dec_tag_o,
  output logic dec_discard_o,
  output logic dec_learn_o,
  output logic [PORT_W-1:0] dec_fwd_mask_o,
  output logic [PORT_W-1:0] dec_mirror_mask_o
);
  import dfg_pkg::*;
  localparam int DW = TAG_W + 2 + 2 * PORT_W;

  dfg_word_t ctrl_reg;
  dfg_byte_t min_tcp_reg;
  dfg_word_t lim4_reg;
  dfg_word_t lim6_reg;
  dfg_byte_t learn_reg;
  dfg_byte_t page_reg;
  dfg_byte_t spi_data_reg [8];
  dfg_byte_t rdata_next;
  logic on_page;
  logic take;
  logic discard_next;
  logic st_valid_reg;
  logic st_valid_next;
  logic [DW-1:0] st_data_reg;
  logic fifo_ready;
  logic [DW-1:0] fifo_out;

  function automatic logic is_over(input dfg_len_t len, input dfg_word_t lim,
                                   input dfg_byte_t extra);
    is_over = {16'h0000, 1'b0, len} > ({1'b0, lim} + {25'h000_0000, extra});
  endfunction

  function automatic dfg_word_t put_byte(input dfg_word_t w, input logic [1:0] lane,
                                          input dfg_byte_t b);
    dfg_word_t r;
    r = w;
    r[lane*8 +: 8] = b;
    put_byte = r;
  endfunction

  // ****************************************************************
  // register page
  // ****************************************************************
  assign on_page = (page_reg == `DFG_PAGE_FLOOD_GUARD);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_reg <= `DFG_RST_CTRL;
      min_tcp_reg <= `DFG_RST_MIN_TCP;
      lim4_reg <= `DFG_RST_ICMP_LIM;
      lim6_reg <= `DFG_RST_ICMP_LIM;
      learn_reg <= `DFG_RST_LEARN;
    end
    else if (reg_req_i && reg_wr_i && on_page)
    begin
      if (reg_addr_i[7:2] == `DFG_OFF_CTRL >> 2)
      begin
        ctrl_reg <= put_byte(ctrl_reg, reg_addr_i[1:0], reg_wdata_i)
                    & 32'h0000_3FFF;
      end
      else if (reg_addr_i == `DFG_OFF_MIN_TCP)
      begin
        min_tcp_reg <= reg_wdata_i;
      end
      else if (reg_addr_i[7:2] == `DFG_OFF_ICMP4_LIM >> 2)
      begin
        lim4_reg <= put_byte(lim4_reg, reg_addr_i[1:0], reg_wdata_i);
      end
      else if (reg_addr_i[7:2] == `DFG_OFF_ICMP6_LIM >> 2)
      begin
        lim6_reg <= put_byte(lim6_reg, reg_addr_i[1:0], reg_wdata_i);
      end
      else if (reg_addr_i == `DFG_OFF_LEARN)
      begin
        learn_reg <= reg_wdata_i;
      end
    end
  end

  // global bytes answer on every page
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      page_reg <= `DFG_RST_PAGE;
      for (int i = 0; i < 8; i++)
      begin
        spi_data_reg[i] <= 8'h00;
      end
    end
    else if (reg_req_i && reg_wr_i)
    begin
      if (reg_addr_i == `DFG_OFF_PAGE)
      begin
        page_reg <= reg_wdata_i;
      end
      else if (reg_addr_i[7:3] == `DFG_OFF_SPI_DATA_LO >> 3)
      begin
        spi_data_reg[reg_addr_i[2:0]] <= reg_wdata_i;
      end
    end
  end

  always_comb
  begin
    rdata_next = 8'h00;
    if (reg_addr_i == `DFG_OFF_PAGE)
    begin
      rdata_next = page_reg;
    end
    else if (reg_addr_i == `DFG_OFF_SPI_STATUS)
    begin
      rdata_next = `DFG_RST_SPI_STATUS;
    end
    else if (reg_addr_i[7:3] == `DFG_OFF_SPI_DATA_LO >> 3)
    begin
      rdata_next = spi_data_reg[reg_addr_i[2:0]];
    end
    else if (!on_page)
    begin
      rdata_next = 8'h00;
    end
    else if (reg_addr_i[7:2] == `DFG_OFF_CTRL >> 2)
    begin
      rdata_next = ctrl_reg[reg_addr_i[1:0]*8 +: 8];
    end
    else if (reg_addr_i == `DFG_OFF_MIN_TCP)
    begin
      rdata_next = min_tcp_reg;
    end
    else if (reg_addr_i[7:2] == `DFG_OFF_ICMP4_LIM >> 2)
    begin
      rdata_next = lim4_reg[reg_addr_i[1:0]*8 +: 8];
    end
    else if (reg_addr_i[7:2] == `DFG_OFF_ICMP6_LIM >> 2)
    begin
      rdata_next = lim6_reg[reg_addr_i[1:0]*8 +: 8];
    end
    else if (reg_addr_i == `DFG_OFF_LEARN)
    begin
      rdata_next = learn_reg;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      reg_ack_o <= 1'b0;
      reg_rdata_o <= 8'h00;
    end
    else
    begin
      reg_ack_o <= reg_req_i;
      reg_rdata_o <= (reg_req_i && !reg_wr_i) ? rdata_next : 8'h00;
    end
  end

  // ****************************************************************
  // per-frame decision stage
  // ****************************************************************
  assign take = hdr_valid_i && hdr_ready_o;
  assign discard_next =
    (ctrl_reg[`DFG_BIT_ICMP6_ECHO] && hdr_ipv6_i && hdr_icmp_i && hdr_echo_req_i
      && !hdr_fragment_i && is_over(hdr_ip_len_i, lim6_reg, 8'h00)) ||
    (ctrl_reg[`DFG_BIT_ICMP4_ECHO] && hdr_ipv4_i && hdr_icmp_i && hdr_echo_req_i
      && !hdr_fragment_i && is_over(hdr_ip_len_i, lim4_reg, hdr_ip_hdr_len_i)) ||
    (ctrl_reg[`DFG_BIT_ICMP6_FRAG] && hdr_ipv6_i && hdr_icmp_i && hdr_fragment_i) ||
    (ctrl_reg[`DFG_BIT_ICMP4_FRAG] && hdr_ipv4_i && hdr_icmp_i && hdr_fragment_i);
  assign st_valid_next = take || (st_valid_reg && !fifo_ready);

  // decision is fixed here, ahead of the queue
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      st_valid_reg <= 1'b0;
      hdr_ready_o <= 1'b0;
      st_data_reg <= '0;
    end
    else
    begin
      st_valid_reg <= st_valid_next;
      hdr_ready_o <= !st_valid_next;
      if (take)
      begin
        st_data_reg <= {hdr_tag_i, discard_next,
          hdr_learn_i && !(discard_next && learn_reg[`DFG_BIT_LEARN_SUPP]),
          discard_next ? {PORT_W{1'b0}} : hdr_fwd_mask_i,
          discard_next ? {PORT_W{1'b0}} : hdr_mirror_mask_i};
      end
    end
  end

  dfg_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(st_valid_reg),
    .in_ready_o(fifo_ready),
    .in_data_i(st_data_reg),
    .out_valid_o(dec_valid_o),
    .out_ready_i(dec_ready_i),
    .out_data_o(fifo_out)
  );

  assign {dec_tag_o, dec_discard_o, dec_learn_o, dec_fwd_mask_o, dec_mirror_mask_o} = fifo_out;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  AST_V6_ECHO: assert property (take && ctrl_reg[13] && hdr_ipv6_i && hdr_icmp_i
    && hdr_echo_req_i && !hdr_fragment_i && ({16'h0, hdr_ip_len_i} > lim6_reg)
    |=> st_data_reg[2*PORT_W+1]) else $error("oversize v6 echo not discarded");
  AST_V4_ECHO: assert property (take && !ctrl_reg[12] && !ctrl_reg[10] && hdr_ipv4_i
    |=> !st_data_reg[2*PORT_W+1]) else $error("v4 frame discarded with checks off");
  AST_V4_LONG: assert property (take && ctrl_reg[12] && hdr_ipv4_i && hdr_icmp_i
    && hdr_echo_req_i && !hdr_fragment_i
    && ({17'h0_0000, hdr_ip_len_i} > ({1'b0, lim4_reg} + {25'h000_0000, hdr_ip_hdr_len_i}))
    |=> st_data_reg[2*PORT_W+1]) else $error("oversize v4 echo not discarded");
  AST_V6_FRAG: assert property (take && ctrl_reg[11] && hdr_ipv6_i && hdr_icmp_i
    && hdr_fragment_i |=> st_data_reg[2*PORT_W+1]) else $error("v6 fragment not discarded");
  AST_V4_FRAG: assert property (take && ctrl_reg[10] && hdr_ipv4_i && hdr_icmp_i
    && hdr_fragment_i |=> st_data_reg[2*PORT_W+1]) else $error("v4 fragment not discarded");
  AST_CTRL_RSVD: assert property (ctrl_reg[31:14] == 18'h0_0000)
    else $error("reserved control bits set");
  AST_LIM_WRITE: assert property (reg_req_i && reg_wr_i && on_page
    && reg_addr_i == 8'h0C |=> lim6_reg[7:0] == $past(reg_wdata_i))
    else $error("v6 limit byte not written");
  AST_PAGE: assert property (reg_req_i && reg_wr_i && reg_addr_i == 8'hFF
    |=> page_reg == $past(reg_wdata_i) ##1 1'b1) else $error("page select not written");
  AST_LIM_RESET: assert property ($fell(reset_i) |-> lim4_reg == 32'd512
    && lim6_reg == 32'd512) else $error("limits not 512 after reset");
  AST_MASK: assert property (dec_valid_o && dec_discard_o |-> dec_fwd_mask_o == '0
    && dec_mirror_mask_o == '0) else $error("discarded frame still forwarded");
  AST_LEARN: assert property (take && learn_reg[0] && discard_next
    |=> !st_data_reg[2*PORT_W]) else $error("discarded frame learned");
  AST_HOLD: assert property (st_valid_reg && !fifo_ready |=> st_valid_reg
    && $stable(st_data_reg)) else $error("decision lost under back-pressure");
  AST_ACK: assert property (reg_req_i
    |=> reg_ack_o ##1 !reg_ack_o || $past(reg_req_i))
    else $error("register access not acknowledged");

  COV_DISCARD: cover property (dec_valid_o && dec_ready_i && dec_discard_o);
  COV_PASS: cover property (dec_valid_o && dec_ready_i && !dec_discard_o);
  COV_FULL: cover property (st_valid_reg && !fifo_ready);
  COV_PAGE: cover property (reg_req_i && reg_wr_i && reg_addr_i == 8'hFF);
endmodule

// File: logic/dfg_defines.svh
// register offsets, field positions, reset values for the flood guard filter
`ifndef DFG_DEFINES_SVH
`define DFG_DEFINES_SVH
`define DFG_PAGE_FLOOD_GUARD 8'h36
`define DFG_OFF_CTRL 8'h00
`define DFG_OFF_MIN_TCP 8'h04
`define DFG_OFF_ICMP4_LIM 8'h08
`define DFG_OFF_ICMP6_LIM 8'h0C
`define DFG_OFF_LEARN 8'h10
`define DFG_OFF_SPI_DATA_LO 8'hF0
`define DFG_OFF_SPI_DATA_HI 8'hF7
`define DFG_OFF_SPI_STATUS 8'hFE
`define DFG_OFF_PAGE 8'hFF
`define DFG_BIT_ICMP6_ECHO 13
`define DFG_BIT_ICMP4_ECHO 12
`define DFG_BIT_ICMP6_FRAG 11
`define DFG_BIT_ICMP4_FRAG 10
`define DFG_CTRL_RW_MSB 13
`define DFG_BIT_LEARN_SUPP 0
`define DFG_RST_CTRL 32'h0000_0001
`define DFG_RST_MIN_TCP 8'h14
`define DFG_RST_ICMP_LIM 32'h0000_0200
`define DFG_RST_LEARN 8'h00
`define DFG_RST_PAGE 8'h00
`define DFG_RST_SPI_STATUS 8'h00
`endif

// File: logic/dfg_pkg.sv
// types shared by the flood guard filter
package dfg_pkg;
  typedef logic [7:0] dfg_byte_t;
  typedef logic [31:0] dfg_word_t;
  typedef logic [15:0] dfg_len_t;
endpackage

// File: tb/dfg_parser_model.sv
// model of the header parser feeding the filter and the forwarding stage draining it
`timescale 1ns/100ps

// ****************************************************************
// parser and forwarding model
// ****************************************************************
module dfg_parser_model #(
  parameter int HW = 56
) (
  input wire logic clk_i,
  input wire logic hdr_ready_i,
  input wire logic [1:0] stall_i,
  output logic hdr_valid_o,
  output logic [HW-1:0] hdr_o,
  output logic dec_ready_o
);
  int seed = 32'hab5e;

  initial
  begin
    hdr_valid_o = 1'b0;
    hdr_o = '0;
  end

  // stall 0 always ready, 1 random, 2 never
  always @(posedge clk_i)
    dec_ready_o <= (stall_i == 2'd0) || (stall_i == 2'd1 && $random(seed) % 2 == 0);

  // holds header until taken, then scrambles the released fields
  task automatic offer(input logic [HW-1:0] h, output bit ok);
    int n;
    n = 0;
    @(posedge clk_i);
    hdr_valid_o <= 1'b1;
    hdr_o <= h;
    @(posedge clk_i);
    while (!hdr_ready_i && n < 1000)
    begin
      n++;
      @(posedge clk_i);
    end
    ok = (n < 1000);
    hdr_valid_o <= 1'b0;
    hdr_o <= ~h;
  endtask
endmodule

// File: tb/tb_top.sv
// self-checking bench of the flood guard filter
`timescale 1ns/100ps

// ****************************************************************
// bench top
// ****************************************************************
module tb_top;
  import dfg_pkg::*;
  localparam int HW = 56;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic reg_req_i = 1'b0;
  logic reg_wr_i = 1'b0;
  dfg_byte_t reg_addr_i = 8'h00;
  dfg_byte_t reg_wdata_i = 8'h00;
  dfg_byte_t reg_rdata_o;
  logic reg_ack_o;
  logic hdr_valid_i;
  logic hdr_ready_o;
  logic [HW-1:0] hdr;
  logic dec_valid_o;
  logic dec_ready_i;
  logic [7:0] dec_tag_o;
  logic dec_discard_o;
  logic dec_learn_o;
  logic [8:0] dec_fwd_mask_o;
  logic [8:0] dec_mirror_mask_o;
  logic [27:0] dec_word;
  logic [1:0] stall = 2'd0;
  int seed = 32'hab5e;
  int n_fail = 0;
  int num_checks = 0;
  dfg_byte_t sh [256];
  logic [27:0] expq [$];

  always #5 clk_i = ~clk_i;

  assign dec_word = {dec_tag_o, dec_discard_o, dec_learn_o, dec_fwd_mask_o, dec_mirror_mask_o};

  dfg_parser_model #(.HW(HW)) i_dfg_parser_model (.clk_i(clk_i), .hdr_ready_i(hdr_ready_o),
    .stall_i(stall), .hdr_valid_o(hdr_valid_i), .hdr_o(hdr), .dec_ready_o(dec_ready_i));

  dfg_filter i_dfg_filter (.clk_i(clk_i), .reset_i(reset_i), .reg_req_i(reg_req_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .hdr_valid_i(hdr_valid_i),
    .hdr_ready_o(hdr_ready_o), .hdr_tag_i(hdr[55:48]), .hdr_ipv4_i(hdr[47]),
    .hdr_ipv6_i(hdr[46]), .hdr_icmp_i(hdr[45]), .hdr_echo_req_i(hdr[44]),
    .hdr_fragment_i(hdr[43]), .hdr_ip_len_i(hdr[42:27]), .hdr_ip_hdr_len_i(hdr[26:19]),
    .hdr_learn_i(hdr[18]), .hdr_fwd_mask_i(hdr[17:9]), .hdr_mirror_mask_i(hdr[8:0]),
    .dec_valid_o(dec_valid_o), .dec_ready_i(dec_ready_i), .dec_tag_o(dec_tag_o),
    .dec_discard_o(dec_discard_o), .dec_learn_o(dec_learn_o),
    .dec_fwd_mask_o(dec_fwd_mask_o), .dec_mirror_mask_o(dec_mirror_mask_o));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic bit vis(input dfg_byte_t a);
    return a == 8'hff || (a >= 8'hf0 && a <= 8'hf7) || sh[255] == 8'h36;
  endfunction

  function automatic dfg_byte_t wmask(input dfg_byte_t a);
    if (a == 8'h01)
      return 8'h3f;
    if (a == 8'h00 || a == 8'h04 || (a >= 8'h08 && a <= 8'h10) || !(a < 8'hf0 || a > 8'hf7))
      return 8'hff;
    return (a == 8'hff) ? 8'hff : 8'h00;
  endfunction

  // expected discard from the shadow config
  function automatic logic exp_disc(input logic [HW-1:0] h);
    logic [31:0] c;
    logic [32:0] l4;
    logic [31:0] l6;
    c = {sh[3], sh[2], sh[1], sh[0]};
    l4 = {1'b0, sh[11], sh[10], sh[9], sh[8]} + h[26:19];
    l6 = {sh[15], sh[14], sh[13], sh[12]};
    return (c[13] & h[46] & h[45] & h[44] & !h[43] & ({16'h0000, h[42:27]} > l6))
      | (c[12] & h[47] & h[45] & h[44] & !h[43] & ({17'h0_0000, h[42:27]} > l4))
      | (c[11] & h[46] & h[45] & h[43])
      | (c[10] & h[47] & h[45] & h[43]);
  endfunction

  task automatic reg_op(input logic wr, input dfg_byte_t a, input dfg_byte_t d,
                        output dfg_byte_t rd);
    @(posedge clk_i);
    reg_req_i <= 1'b1;
    reg_wr_i <= wr;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_req_i <= 1'b0;
    @(posedge clk_i);
    check("reg_ack_o", 32'h0000_0001, {31'h0, reg_ack_o});
    rd = reg_rdata_o;
  endtask

  task automatic wr(input dfg_byte_t a, input dfg_byte_t d);
    dfg_byte_t r;
    reg_op(1'b1, a, d, r);
    if (vis(a))
      sh[a] = d & wmask(a);
  endtask

  task automatic wr32(input dfg_byte_t a, input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      wr(a + 8'(i), v[8*i+:8]);
  endtask

  task automatic scan_all(input string name);
    dfg_byte_t r;
    dfg_byte_t e;
    for (int a = 0; a < 256; a++)
    begin
      reg_op(1'b0, 8'(a), 8'h00, r);
      e = vis(8'(a)) ? sh[a] : 8'h00;
      if (a < 16)
        check("reg_rdata_o", 32'(e), 32'(r));
      else if (a == 16)
        check("reg_rdata_o", 32'(e), 32'(r));
      else
        check("reg_rdata_o", 32'(e), 32'(r));
    end
    $display("test %s done", name);
  endtask

  task automatic rnd_frame(output logic [HW-1:0] h);
    logic [15:0] base;
    h = HW'({$random(seed), $random(seed)});
    h[46] = !h[47];
    base = h[47] ? ({sh[9], sh[8]} + h[26:19]) : {sh[13], sh[12]};
    h[42:27] = base - 16'h0001 + 16'($unsigned($random(seed)) % 3);
  endtask

  task automatic send(input logic [HW-1:0] h);
    bit ok;
    logic d;
    i_dfg_parser_model.offer(h, ok);
    if (!ok)
    begin
      check("hdr_taken", 32'h0000_0001, 32'h0000_0000);
      give_verdict();
    end
    d = exp_disc(h);
    expq.push_back({h[55:48], d, h[18] & !(d & sh[16][0]), d ? 18'h0_0000 : h[17:0]});
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (expq.size() != 0 && n < 3000)
    begin
      n++;
      @(posedge clk_i);
    end
    if (expq.size() != 0)
    begin
      check("expq_size", 32'h0000_0000, 32'(expq.size()));
      give_verdict();
    end
  endtask

  always @(posedge clk_i)
    if (dec_valid_o === 1'b1 && dec_ready_i)
    begin
      if (expq.size() == 0)
        check("dec_valid_o", 32'h0000_0000, 32'h0000_0001);
      else
        check("decision", 32'(expq.pop_front()), 32'(dec_word));
    end

  initial
  begin
    logic [HW-1:0] h;
    logic [31:0] c;
    foreach (sh[i])
      sh[i] = 8'h00;
    sh[0] = 8'h01;
    sh[4] = 8'h14;
    sh[9] = 8'h02;
    sh[13] = 8'h02;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    scan_all("reset_other_page");
    wr(8'hff, 8'h36);
    scan_all("reset_values");
    for (int a = 0; a < 255; a++)
      wr(8'(a), 8'($random(seed)));
    scan_all("write_readback");
    for (int k = 0; k < 6; k++)
    begin
      c = (k < 4) ? (32'h0000_0400 << k) : (k == 4 ? 32'($random(seed)) : 32'h0000_3c00);
      wr32(8'h00, c);
      wr32(8'h08, 32'($random(seed)) & 32'h0000_0fff);
      wr32(8'h0c, 32'($random(seed)) & 32'h0000_0fff);
      wr(8'h10, {7'h00, k[0]});
      stall <= {1'b0, k[0]};
      for (int j = 0; j < 30; j++)
      begin
        rnd_frame(h);
        send(h);
      end
      drain();
    end
    $display("test frames done");
    stall <= 2'd2;
    fork
      for (int j = 0; j < 40; j++)
      begin
        rnd_frame(h);
        send(h);
      end
      begin
        repeat (400) @(posedge clk_i);
        check("hdr_ready_o", 32'h0000_0000, {31'h0, hdr_ready_o});
        stall <= 2'd1;
      end
    join
    drain();
    $display("test fifo_fill done");
    give_verdict();
  end
endmodule
